//--- core/sse_pkg.sv
// Shared constants of the serial slave engine
package sse_pkg;
  localparam int DATA_W = 16;
  localparam int DEPTH = 8;
  localparam int PTR_W = 3;
  localparam int CNT_W = 4;
  localparam int LEN_W = 4;
  localparam int NDF_W = 16;
  localparam logic [CNT_W-1:0] FIFO_FULL = 4'h8;
  localparam logic [LEN_W-1:0] LEN_MIN_M1 = 4'h3;
  localparam logic [DATA_W-1:0] WORD_RST = 16'h0000;
  localparam logic [NDF_W-1:0] NDF_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [PTR_W-1:0] PTR_ONE = 3'h1;
  localparam logic [LEN_W-1:0] BIT_ONE = 4'h1;

  typedef enum logic [1:0] {
    SSE_TM_TXRX = 2'b00,
    SSE_TM_TX = 2'b01,
    SSE_TM_RX = 2'b10,
    SSE_TM_MEMRD = 2'b11
  } sse_transfer_mode_field_t;

  typedef enum logic [1:0] {
    SSE_PR_SPI = 2'b00,
    SSE_PR_SSP = 2'b01,
    SSE_PR_CW = 2'b10
  } sse_proto_t;
endpackage : sse_pkg

//--- core/sse_sync.sv
// Two-flop synchroniser for a group of levels
`timescale 1ns/1ns
`default_nettype none
module sse_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : sse_sync
`default_nettype wire

//--- core/sse_mem.sv
// Small word memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module sse_mem (
  input wire logic clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [sse_pkg::PTR_W-1:0] waddr,
  input wire logic [sse_pkg::DATA_W-1:0] wdata,
  input wire logic [sse_pkg::PTR_W-1:0] raddr,
  output logic [sse_pkg::DATA_W-1:0] rdata
);
  logic [sse_pkg::DATA_W-1:0] mem [sse_pkg::DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= sse_pkg::WORD_RST;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule : sse_mem
`default_nettype wire

//--- core/sse_engine.sv
// Serial slave engine: link shifter, transmit and receive queues
//
// Functional notes
// - Selected slave drives its transmit line when output enable is set; deselected it leaves it undriven.
// - Outgoing bits launch on one serial clock edge, sampled on the other.
// - Transmit line high impedance when idle; active-low enable for buffer.
// - Idle until selected; frames continue while select stays asserted.
// - Output-enable control bit decides whether slave answers with data.
// - Receive-only resends current shift word; no underflow flag there.
// - Empty transmit queue at selection or after a finished frame sets underflow, resends last.
// - Transmit-empty interrupt when level reaches transmit threshold.
// - Early nearly-full indication by receive threshold; full interrupt too.
// - Receive DMA request when level exceeds receive DMA level.
// - Control-word protocol frames pass through as ordinary data.
// - Master select glue: high enables SPI/control-word, low enables SSP.
// - Polarity fixes serial clock idle level; frames 4 to 16 bits.
// - Phase zero: first bit valid before first serial clock edge.
// - Master role starts shifting when output enable deasserts.
// - Mode 0 transmits from queue and stores every received word that finds room in the receive queue.
// - Mode 1 transmits and discards received words.
// - Mode 2 keeps transmit level constant, stores received words.
// - Mode 3 sends command frames uncaptured, then stores returned data.
// - Modes 2 and 3 end after frame count field plus one frames.
// - SSP frame indicator pulse one clock, data one clock later.
`timescale 1ns/1ns
`default_nettype none
module sse_engine (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic sclk_in,
  input wire logic ss_in_n,
  input wire logic rxd,
  output logic txd_o,
  output logic txd_oe,
  output logic slave_txd_oe_n,
  input wire logic [1:0] transfer_mode_field,
  input wire logic [1:0] protocol_sel,
  input wire logic slave_output_enable,
  input wire logic clock_polarity_setting,
  input wire logic [sse_pkg::LEN_W-1:0] frame_len_m1,
  input wire logic [sse_pkg::NDF_W-1:0] frame_count_field,
  input wire logic [sse_pkg::CNT_W-1:0] tx_threshold_level,
  input wire logic [sse_pkg::CNT_W-1:0] rx_threshold_level,
  input wire logic [sse_pkg::CNT_W-1:0] rx_dma_request_level,
  input wire logic tx_wr_valid,
  input wire logic [sse_pkg::DATA_W-1:0] tx_wr_data,
  output logic tx_wr_ready,
  input wire logic rx_rd_ready,
  output logic rx_rd_valid,
  output logic [sse_pkg::DATA_W-1:0] rx_rd_data,
  input wire logic underflow_clear,
  output logic transmit_underflow_error,
  output logic tx_empty_irq,
  output logic rx_threshold_irq,
  output logic rx_full_irq,
  output logic rx_dma_req,
  output logic busy,
  output logic xfer_done,
  input wire logic master_ss_in_n,
  input wire logic master_oe_n,
  output logic master_xfer_enable,
  output logic master_start
);

  // ==========================================================
  // Declarations
  function automatic logic [sse_pkg::PTR_W-1:0] ptr_inc(
    input logic [sse_pkg::PTR_W-1:0] p
  );
    ptr_inc = p + sse_pkg::PTR_ONE;
  endfunction : ptr_inc

  function automatic logic [sse_pkg::CNT_W-1:0] cnt_upd(
    input logic [sse_pkg::CNT_W-1:0] c,
    input logic inc,
    input logic dec
  );
    cnt_upd = c;
    if (inc && !dec) begin
      cnt_upd = c + sse_pkg::CNT_ONE;
    end else if (dec && !inc) begin
      cnt_upd = c - sse_pkg::CNT_ONE;
    end
  endfunction : cnt_upd

  logic sck;
  logic ssp;
  logic link_rst;
  logic [sse_pkg::LEN_W-1:0] bit_cnt_l;
  logic [sse_pkg::DATA_W-1:0] rx_shift_l;
  logic [sse_pkg::DATA_W-1:0] rx_word_l;
  logic done_tgl_l;
  logic launched_l;
  logic txd_bit_l;
  logic [sse_pkg::LEN_W-1:0] len_m1;
  logic last_bit;
  logic [sse_pkg::DATA_W-1:0] rx_shift_nxt;

  logic [2:0] sync_in;
  logic [2:0] sync_out;
  logic sel_s;
  logic tgl_s;
  logic mss_s;
  logic sel_d_r;
  logic tgl_d_r;
  logic oe_s;
  logic oe_d_r;
  logic frame_ev;
  logic start_ev;

  logic [sse_pkg::DATA_W-1:0] tx_hold_r;
  logic [sse_pkg::PTR_W-1:0] tx_wp_r;
  logic [sse_pkg::PTR_W-1:0] tx_rp_r;
  logic [sse_pkg::CNT_W-1:0] tx_cnt_r;
  logic tx_hv_r;
  logic [sse_pkg::DATA_W-1:0] tx_head;
  logic tx_push;
  logic tx_pop;
  logic tx_load;
  logic cmd_frame_r;

  logic [sse_pkg::PTR_W-1:0] rx_wp_r;
  logic [sse_pkg::PTR_W-1:0] rx_rp_r;
  logic [sse_pkg::CNT_W-1:0] rx_cnt_r;
  logic rx_push;
  logic rx_pop;
  logic store_ok;
  logic [sse_pkg::NDF_W-1:0] frames_r;
  logic counted;

  // ==========================================================
  // Link side, clocked by the master's serial clock
  // Polarity folds the idle level so sampling is always on rising sck
  assign sck = sclk_in ^ clock_polarity_setting;
  assign ssp = (protocol_sel == sse_pkg::SSE_PR_SSP);
  // SPI select is a frame envelope and clears the shifter; SSP uses pulses
  assign link_rst = sys_rst | (ss_in_n & ~ssp);
  assign len_m1 = (frame_len_m1 < sse_pkg::LEN_MIN_M1) ?
      sse_pkg::LEN_MIN_M1 : frame_len_m1;
  assign last_bit = (bit_cnt_l == len_m1);
  assign rx_shift_nxt = {rx_shift_l[sse_pkg::DATA_W-2:0], rxd};

  always_ff @(posedge sck or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt_l <= '0;
      rx_shift_l <= sse_pkg::WORD_RST;
    end else if (ssp && ss_in_n) begin
      // Frame indicator pulse: data start on the following clock
      bit_cnt_l <= '0;
    end else if (last_bit) begin
      bit_cnt_l <= '0;
      rx_shift_l <= sse_pkg::WORD_RST;
    end else begin
      bit_cnt_l <= bit_cnt_l + sse_pkg::BIT_ONE;
      rx_shift_l <= rx_shift_nxt;
    end
  end

  // Finished word and its event toggle survive deselection
  always_ff @(posedge sck or posedge sys_rst) begin
    if (sys_rst) begin
      rx_word_l <= sse_pkg::WORD_RST;
      done_tgl_l <= 1'b0;
    end else if (last_bit && !(ssp && ss_in_n)) begin
      // Control-word frames are not decoded, just passed on
      rx_word_l <= rx_shift_nxt;
      done_tgl_l <= ~done_tgl_l;
    end
  end

  // Launch on the falling edge, half a clock ahead of the sample
  always_ff @(negedge sck or posedge link_rst) begin
    if (link_rst) begin
      launched_l <= 1'b0;
      txd_bit_l <= 1'b0;
    end else begin
      // After the last bit the line falls back to the next word's lead bit
      launched_l <= (bit_cnt_l != '0);
      txd_bit_l <= tx_hold_r[len_m1 - bit_cnt_l];
    end
  end

  // Before the first edge the leading bit already stands on the line
  assign txd_o = launched_l ? txd_bit_l : tx_hold_r[len_m1];

  // ==========================================================
  // Crossing into the controller clock
  assign sync_in = {master_ss_in_n, done_tgl_l, ~ss_in_n};

  sse_sync #(
    .W(3)
  ) u_sync (
    .clk(mclk),
    .rst(sys_rst),
    .d(sync_in),
    .q(sync_out)
  );

  assign sel_s = sync_out[0];
  assign tgl_s = sync_out[1];
  assign mss_s = sync_out[2];

  sse_sync #(
    .W(1)
  ) u_sync_oe (
    .clk(mclk),
    .rst(sys_rst),
    .d(master_oe_n),
    .q(oe_s)
  );

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sel_d_r <= 1'b0;
      tgl_d_r <= 1'b0;
      oe_d_r <= 1'b0;
    end else begin
      sel_d_r <= sel_s;
      tgl_d_r <= tgl_s;
      oe_d_r <= oe_s;
    end
  end

  assign frame_ev = tgl_s ^ tgl_d_r;
  assign start_ev = sel_s & ~sel_d_r;

  // ==========================================================
  // Pin drive
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      txd_oe <= 1'b0;
      slave_txd_oe_n <= 1'b1;
      busy <= 1'b0;
    end else begin
      txd_oe <= sel_s & slave_output_enable;
      slave_txd_oe_n <= ~(sel_s & slave_output_enable);
      busy <= sel_s;
    end
  end

  // ==========================================================
  // Transmit queue
  assign tx_push = tx_wr_valid && tx_wr_ready;
  // A new word is due at selection and after each finished frame
  assign tx_load = start_ev || (frame_ev && sel_s);
  assign tx_pop = tx_load && tx_hv_r &&
      (transfer_mode_field != sse_pkg::SSE_TM_RX);

  sse_mem u_tx_mem (
    .clk(mclk),
    .rst(sys_rst),
    .we(tx_push),
    .waddr(tx_wp_r),
    .wdata(tx_wr_data),
    .raddr(tx_rp_r),
    .rdata(tx_head)
  );

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_wp_r <= '0;
      tx_rp_r <= '0;
      tx_cnt_r <= '0;
      tx_hv_r <= 1'b0;
      tx_wr_ready <= 1'b0;
    end else begin
      if (tx_push) begin
        tx_wp_r <= ptr_inc(tx_wp_r);
      end
      if (tx_pop) begin
        tx_rp_r <= ptr_inc(tx_rp_r);
      end
      tx_cnt_r <= cnt_upd(tx_cnt_r, tx_push, tx_pop);
      tx_hv_r <= (tx_cnt_r != '0) && !tx_pop;
      tx_wr_ready <= (cnt_upd(tx_cnt_r, tx_push, tx_pop) !=
          sse_pkg::FIFO_FULL);
    end
  end

  // Shift word: an empty queue leaves the previous word to be resent
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_hold_r <= sse_pkg::WORD_RST;
    end else if (tx_pop) begin
      tx_hold_r <= tx_head;
    end
  end

  // Marks a frame that carries a queued command word
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_frame_r <= 1'b0;
    end else if (tx_load) begin
      cmd_frame_r <= tx_pop;
    end
  end

  // Sticky underflow, set wins over clear
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      transmit_underflow_error <= 1'b0;
    end else if (tx_load && !tx_hv_r &&
        transfer_mode_field != sse_pkg::SSE_TM_RX) begin
      transmit_underflow_error <= 1'b1;
    end else if (underflow_clear) begin
      transmit_underflow_error <= 1'b0;
    end
  end

  // ==========================================================
  // Receive queue
  // Memory read discards until the command frames are gone
  always_comb begin
    unique case (transfer_mode_field)
      sse_pkg::SSE_TM_TXRX: store_ok = 1'b1;
      sse_pkg::SSE_TM_TX: store_ok = 1'b0;
      sse_pkg::SSE_TM_RX: store_ok = !xfer_done;
      sse_pkg::SSE_TM_MEMRD: store_ok = !xfer_done && !cmd_frame_r;
    endcase
  end

  // Overflowing words are dropped while the queue is full
  assign rx_push = frame_ev && store_ok && (rx_cnt_r != sse_pkg::FIFO_FULL);
  assign rx_pop = rx_rd_valid && rx_rd_ready;
  assign counted = (transfer_mode_field == sse_pkg::SSE_TM_RX) ||
      (transfer_mode_field == sse_pkg::SSE_TM_MEMRD);

  sse_mem u_rx_mem (
    .clk(mclk),
    .rst(sys_rst),
    .we(rx_push),
    .waddr(rx_wp_r),
    .wdata(rx_word_l),
    .raddr(rx_rp_r),
    .rdata(rx_rd_data)
  );

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_wp_r <= '0;
      rx_rp_r <= '0;
      rx_cnt_r <= '0;
      rx_rd_valid <= 1'b0;
    end else begin
      if (rx_push) begin
        rx_wp_r <= ptr_inc(rx_wp_r);
      end
      if (rx_pop) begin
        rx_rp_r <= ptr_inc(rx_rp_r);
      end
      rx_cnt_r <= cnt_upd(rx_cnt_r, rx_push, rx_pop);
      rx_rd_valid <= (rx_cnt_r != '0) && !rx_pop;
    end
  end

  // Frame count of receive-only and memory read, rearmed per selection
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      frames_r <= '0;
      xfer_done <= 1'b0;
    end else if (start_ev) begin
      frames_r <= '0;
      xfer_done <= 1'b0;
    end else if (rx_push && counted) begin
      frames_r <= frames_r + sse_pkg::NDF_ONE;
      if (frames_r + sse_pkg::NDF_ONE ==
          frame_count_field + sse_pkg::NDF_ONE) begin
        xfer_done <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Level indications
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_empty_irq <= 1'b0;
      rx_threshold_irq <= 1'b0;
      rx_full_irq <= 1'b0;
      rx_dma_req <= 1'b0;
    end else begin
      tx_empty_irq <= (tx_cnt_r <= tx_threshold_level);
      rx_threshold_irq <= (rx_cnt_r > rx_threshold_level);
      rx_full_irq <= (rx_cnt_r == sse_pkg::FIFO_FULL);
      rx_dma_req <= (rx_cnt_r > rx_dma_request_level);
    end
  end

  // ==========================================================
  // Master-role select glue
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      master_xfer_enable <= 1'b0;
      master_start <= 1'b0;
    end else begin
      master_xfer_enable <= ssp ? ~mss_s : mss_s;
      master_start <= oe_s & ~oe_d_r;
    end
  end

endmodule : sse_engine
`default_nettype wire

//--- verif/sse_engine_asserts.sv
// Port checks for the serial slave engine
`timescale 1ns/1ns
`default_nettype none
module sse_engine_asserts (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ss_in_n,
  input wire logic txd_oe,
  input wire logic slave_txd_oe_n,
  input wire logic slave_output_enable,
  input wire logic [1:0] transfer_mode_field,
  input wire logic [1:0] protocol_sel,
  input wire logic transmit_underflow_error,
  input wire logic underflow_clear,
  input wire logic master_ss_in_n,
  input wire logic master_oe_n,
  input wire logic master_xfer_enable,
  input wire logic master_start
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // Link output drive
  oe_pair_a: assert property (
    txd_oe != slave_txd_oe_n) else $error("buffer enable not inverse");
  desel_quiet_a: assert property (
    (ss_in_n && protocol_sel == 2'b00) [*5] |-> !txd_oe)
    else $error("drives while deselected");
  sel_drive_a: assert property (
    (!ss_in_n && slave_output_enable && protocol_sel == 2'b00) [*5]
    |-> txd_oe) else $error("silent while selected");
  no_answer_a: assert property (
    !slave_output_enable [*3] |-> !txd_oe) else $error("answers when off");
  // ==========================================================
  // Underflow flag
  rx_no_flag_a: assert property (
    $rose(transmit_underflow_error) |-> $past(transfer_mode_field) != 2'b10)
    else $error("underflow in receive only");
  flag_sticky_a: assert property (
    transmit_underflow_error && !underflow_clear |=> transmit_underflow_error)
    else $error("underflow flag lost");
  // ==========================================================
  // Master glue
  glue_ssp_a: assert property (
    (protocol_sel == 2'b01 && master_ss_in_n) [*5] |-> !master_xfer_enable)
    else $error("frame protocol enabled by high");
  glue_spi_a: assert property (
    (protocol_sel == 2'b00 && master_ss_in_n) [*5] |-> master_xfer_enable)
    else $error("spi not enabled by high");
  start_follow_a: assert property (
    $rose(master_oe_n) |-> ##[1:5] master_start) else $error("no start");
  start_once_a: assert property (
    master_start |=> !master_start) else $error("start pulse too long");
endmodule : sse_engine_asserts
bind sse_engine sse_engine_asserts chk_u (.mclk, .sys_rst, .ss_in_n, .txd_oe,
  .slave_txd_oe_n, .slave_output_enable, .transfer_mode_field, .protocol_sel,
  .transmit_underflow_error, .underflow_clear, .master_ss_in_n, .master_oe_n,
  .master_xfer_enable, .master_start);
`default_nettype wire

//--- verif/sse_spi_master.sv
// Serial master model driving link clock, select and data
`timescale 1ns/1ns
`default_nettype none
module sse_spi_master (
  output logic sclk_in,
  output logic ss_in_n,
  output logic rxd,
  input wire logic txd_o,
  input wire logic txd_oe
);
  logic cpol;
  initial begin
    cpol = 1'b0;
    sclk_in = 1'b0;
    ss_in_n = 1'b1;
    rxd = 1'b0;
  end
  // Select setup and frame gap both exceed four controller cycles
  task automatic sel(input logic on);
    ss_in_n = !on;
    if (!on)
      rxd = !rxd;
    #500;
  endtask : sel
  // Idle level of the link clock follows the polarity setting
  task automatic idle(input logic lvl);
    cpol = lvl;
    sclk_in = lvl;
  endtask : idle
  task automatic frame(input int n, input logic [15:0] mo,
                       output logic [15:0] so);
    so = 16'h0000;
    for (int i = n - 1; i >= 0; i--) begin
      rxd = mo[i];
      #2 so[i] = txd_oe ? txd_o : 1'bx;
      #1 sclk_in = !cpol;
      #3 sclk_in = cpol;
    end
    #500;
  endtask : frame
endmodule : sse_spi_master
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench for the serial slave engine
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  wire logic sclk_in, ss_in_n, rxd;
  logic txd_o, txd_oe, slave_txd_oe_n, tx_wr_ready, rx_rd_valid;
  logic transmit_underflow_error, tx_empty_irq, rx_threshold_irq;
  logic rx_full_irq, rx_dma_req, busy, xfer_done, master_xfer_enable;
  logic master_start;
  logic [15:0] rx_rd_data;
  logic [1:0] transfer_mode_field = 2'h0;
  logic [1:0] protocol_sel = 2'h0;
  logic slave_output_enable = 1'b1;
  logic clock_polarity_setting = 1'b0;
  logic [3:0] frame_len_m1 = 4'hF;
  logic [15:0] frame_count_field = 16'h0000;
  logic [3:0] tx_threshold_level = 4'h0;
  logic [3:0] rx_threshold_level = 4'h0;
  logic [3:0] rx_dma_request_level = 4'h0;
  logic tx_wr_valid = 1'b0;
  logic [15:0] tx_wr_data = 16'h0000;
  logic rx_rd_ready = 1'b0;
  logic underflow_clear = 1'b0;
  logic master_ss_in_n = 1'b0;
  logic master_oe_n = 1'b0;
  int checked = 0;
  int miscompares = 0;
  int cycles = 0;
  sse_engine dut_u (.mclk, .sys_rst, .sclk_in, .ss_in_n, .rxd, .txd_o,
    .txd_oe, .slave_txd_oe_n, .transfer_mode_field, .protocol_sel,
    .slave_output_enable, .clock_polarity_setting, .frame_len_m1,
    .frame_count_field, .tx_threshold_level, .rx_threshold_level,
    .rx_dma_request_level, .tx_wr_valid, .tx_wr_data, .tx_wr_ready,
    .rx_rd_ready, .rx_rd_valid, .rx_rd_data, .underflow_clear,
    .transmit_underflow_error, .tx_empty_irq, .rx_threshold_irq,
    .rx_full_irq, .rx_dma_req, .busy, .xfer_done, .master_ss_in_n,
    .master_oe_n, .master_xfer_enable, .master_start);
  sse_spi_master mst_u (.sclk_in, .ss_in_n, .rxd, .txd_o, .txd_oe);
  always #50 mclk = !mclk;
  // ==========================================================
  // Access tasks
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [15:0] ex,
                     input logic [15:0] got);
    checked++;
    if (got !== ex) begin
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
      miscompares++;
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  task automatic push(input logic [15:0] w);
    tx_wr_valid = 1'b1;
    tx_wr_data = w;
    for (int k = 0; k < 20 && tx_wr_ready !== 1'b1; k++)
      cyc(1);
    cyc(1);
    tx_wr_valid = 1'b0;
    cyc(2);
  endtask : push
  task automatic pop(input logic [15:0] ex);
    for (int k = 0; k < 20 && rx_rd_valid !== 1'b1; k++)
      cyc(1);
    chk("rx word", ex, rx_rd_data);
    rx_rd_ready = 1'b1;
    cyc(1);
    rx_rd_ready = 1'b0;
    cyc(1);
  endtask : pop
  task automatic fr(input int n, input logic [15:0] mo,
                    output logic [15:0] so);
    mst_u.frame(n, mo, so);
    cyc(1);
  endtask : fr
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      print_verdict();
    end
  end
  // ==========================================================
  // Tests
  initial begin
    logic [15:0] got;
    repeat (10) @(posedge mclk);
    #1 sys_rst = 1'b0;
    cyc(2);
    chk("oe_n idle", 16'h0001, slave_txd_oe_n);
    chk("tx empty irq", 16'h0001, tx_empty_irq);
    push(16'hC3A5);
    push(16'h5A96);
    chk("tx empty irq", 16'h0000, tx_empty_irq);
    tx_threshold_level = 4'h2;
    cyc(2);
    chk("tx thr level", 16'h0001, tx_empty_irq);
    $display("test reset done");
    mst_u.sel(1'b1);
    fr(16, 16'h1234, got);
    chk("tx word", 16'hC3A5, got);
    chk("drive", 16'h0001, txd_oe);
    chk("busy", 16'h0001, busy);
    fr(16, 16'hFEDC, got);
    chk("tx word", 16'h5A96, got);
    fr(16, 16'h0F0F, got);
    chk("resent", 16'h5A96, got);
    chk("underflow", 16'h0001, transmit_underflow_error);
    mst_u.sel(1'b0);
    cyc(1);
    chk("released", 16'h0001, slave_txd_oe_n);
    chk("idle", 16'h0000, busy);
    chk("rx thr irq", 16'h0001, rx_threshold_irq);
    chk("rx dma", 16'h0001, rx_dma_req);
    rx_threshold_level = 4'h2;
    rx_dma_request_level = 4'h3;
    cyc(2);
    chk("rx thr level", 16'h0001, rx_threshold_irq);
    chk("rx dma level", 16'h0000, rx_dma_req);
    pop(16'h1234);
    pop(16'hFEDC);
    pop(16'h0F0F);
    underflow_clear = 1'b1;
    cyc(1);
    underflow_clear = 1'b0;
    cyc(2);
    chk("underflow clr", 16'h0000, transmit_underflow_error);
    $display("test txrx done");
    transfer_mode_field = 2'h2;
    frame_count_field = 16'h0007;
    mst_u.sel(1'b1);
    for (int f = 0; f < 8; f++) begin
      fr(16, 16'h8001 ^ {4{4'(f)}}, got);
      chk("count done", 16'(f == 7), xfer_done);
    end
    chk("rx full", 16'h0001, rx_full_irq);
    chk("no underflow", 16'h0000, transmit_underflow_error);
    mst_u.sel(1'b0);
    cyc(1);
    for (int f = 0; f < 8; f++)
      pop(16'h8001 ^ {4{4'(f)}});
    $display("test rx only done");
    transfer_mode_field = 2'h3;
    frame_count_field = 16'h0000;
    push(16'h0300);
    mst_u.sel(1'b1);
    fr(16, 16'hFFFF, got);
    chk("cmd out", 16'h0300, got);
    chk("cmd dropped", 16'h0000, rx_rd_valid);
    fr(16, 16'h00C3, got);
    chk("mem done", 16'h0001, xfer_done);
    mst_u.sel(1'b0);
    cyc(1);
    pop(16'h00C3);
    $display("test memory read done");
    transfer_mode_field = 2'h1;
    frame_len_m1 = 4'h3;
    clock_polarity_setting = 1'b1;
    mst_u.idle(1'b1);
    push(16'hAAAA);
    mst_u.sel(1'b1);
    fr(4, 16'h0006, got);
    chk("short frame", 16'h000A, got);
    cyc(3);
    chk("rx discarded", 16'h0000, rx_rd_valid);
    mst_u.sel(1'b0);
    cyc(1);
    slave_output_enable = 1'b0;
    mst_u.sel(1'b1);
    cyc(5);
    chk("no answer", 16'h0000, txd_oe);
    mst_u.sel(1'b0);
    cyc(1);
    slave_output_enable = 1'b1;
    $display("test tx only done");
    for (int p = 0; p < 3; p++) begin
      for (int v = 0; v < 2; v++) begin
        protocol_sel = p[1:0];
        master_ss_in_n = v[0];
        cyc(5);
        chk("master enable", 16'(v[0] ^ (p == 1)), master_xfer_enable);
      end
    end
    protocol_sel = 2'h0;
    master_oe_n = 1'b1;
    for (int k = 0; k < 8 && master_start !== 1'b1; k++)
      cyc(1);
    chk("start", 16'h0001, master_start);
    cyc(1);
    chk("start end", 16'h0000, master_start);
    $display("test master glue done");
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
